// [hdl/csw_config_switch.sv]
// configuration switch port selector: control register, bus routing, indicate ports
`timescale 1ns/10ps

module csw_config_switch
	import csw_pkg::*;
#(
	parameter bit          HAS_SECOND_PORT = 1'b1,
	parameter int unsigned HALT_PAIR_MAX   = 8
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire csw_bus_t   receiver_bus,
	input  wire csw_bus_t   request_a_bus,
	input  wire csw_bus_t   request_b_bus,
	output csw_bus_t        tx_input,
	output csw_bus_t        first_indicate_bus,
	output logic            first_indicate_oe,
	output csw_bus_t        second_indicate_bus,
	output logic            second_indicate_oe
);

	// ****************************************************************
	// types and functions
	// ****************************************************************

	typedef enum logic [3:0] {
		RF_PASS   = 4'h1,
		RF_HALT_1 = 4'h2,
		RF_HALT_2 = 4'h4,
		RF_IDLE   = 4'h8
	} csw_rf_state_t;

	localparam int          CNT_W     = $clog2(HALT_PAIR_MAX + 1);
	localparam logic [CNT_W-1:0] PAIR_LIMIT = CNT_W'(HALT_PAIR_MAX);

	// odd parity over control and data, matching the through-parity buses
	function automatic csw_bus_t make_symbol(input logic [7:0] code);
		csw_bus_t s;
		s.control = 1'b1;
		s.data    = code;
		s.parity  = ~(^{1'b1, code});
		return s;
	endfunction

	// the one switch decode, used by both selectors
	function automatic csw_bus_t pick_bus(
		input csw_bus_sel_t sel,
		input csw_bus_t     rcv,
		input csw_bus_t     req_a,
		input csw_bus_t     req_b
	);
		csw_bus_t b;
		case (sel)
			CSW_BUS_INVALID:  b = make_symbol(CSW_SYM_INVALID);
			CSW_BUS_RECEIVER: b = rcv;
			CSW_BUS_REQ_A:    b = req_a;
			CSW_BUS_REQ_B:    b = req_b;
			default:          b = make_symbol(CSW_SYM_INVALID);
		endcase
		return b;
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************

	logic [7:0]       config_reg;
	logic [2:0]       transmit_mode_field;
	csw_rf_state_t    rf_state;
	csw_rf_state_t    next_rf_state;
	logic [CNT_W-1:0] halt_pairs;
	csw_bus_sel_t     tx_sel;
	csw_bus_sel_t     second_sel;
	logic             first_indicate_port_enable;
	logic             second_indicate_port_enable;
	logic             tx_source_select_lo;
	logic             tx_source_select_hi;
	logic             second_indicate_select_lo;
	logic             second_indicate_select_hi;
	logic             invalid_active;
	csw_bus_t         switch_tx;
	csw_bus_t         switch_second;
	logic [7:0]       status_word;

	// field views of the configuration register
	assign second_indicate_select_lo   = config_reg[CSW_BIT_SECOND_SEL_LO];
	assign second_indicate_select_hi   = config_reg[CSW_BIT_SECOND_SEL_HI];
	assign tx_source_select_lo         = config_reg[CSW_BIT_TX_SEL_LO];
	assign tx_source_select_hi         = config_reg[CSW_BIT_TX_SEL_HI];
	assign first_indicate_port_enable  = config_reg[CSW_BIT_FIRST_ENABLE];
	assign second_indicate_port_enable = config_reg[CSW_BIT_SECOND_ENABLE];

	// configuration register; second-port bits are kept even on the
	// single-path variant so software reads back what it wrote
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			config_reg <= CSW_CONFIG_RESET;
		end else if (reg_wr && reg_addr == CSW_ADDR_CONFIG) begin
			config_reg <= reg_wdata & CSW_CONFIG_WR_MASK;
		end
	end

	// transmit mode field of the transmit state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_mode_field <= CSW_TM_RESET;
		end else if (reg_wr && reg_addr == CSW_ADDR_TX_STATE) begin
			transmit_mode_field <= reg_wdata[CSW_TM_MSB:CSW_TM_LSB];
		end
	end

	// ****************************************************************
	// configuration switch
	// ****************************************************************

	// both selectors use the same two-bit bus encoding
	always_comb begin
		tx_sel     = csw_bus_sel_t'({tx_source_select_hi, tx_source_select_lo});
		second_sel = csw_bus_sel_t'({second_indicate_select_hi, second_indicate_select_lo});
	end

	// routing of the four switch buses
	always_comb begin
		switch_tx     = pick_bus(tx_sel, receiver_bus, request_a_bus, request_b_bus);
		switch_second = pick_bus(second_sel, receiver_bus, request_a_bus, request_b_bus);
	end

	// ****************************************************************
	// repeat filter on the transmit path
	// ****************************************************************

	// the filter only engages while actively transmitting an invalid bus
	assign invalid_active = (tx_sel == CSW_BUS_INVALID) && (transmit_mode_field == CSW_TM_ACTIVE);

	// next state: halt pairs are emitted whole, then idle holds until
	// the condition goes away; leaving it restarts the pair budget
	always_comb begin
		next_rf_state = rf_state;
		case (rf_state)
			RF_PASS: begin
				if (invalid_active) begin
					next_rf_state = (PAIR_LIMIT == '0) ? RF_IDLE : RF_HALT_1;
				end
			end
			RF_HALT_1: begin
				next_rf_state = RF_HALT_2;
			end
			RF_HALT_2: begin
				if (!invalid_active) begin
					next_rf_state = RF_PASS;
				end else if (halt_pairs == PAIR_LIMIT) begin
					next_rf_state = RF_IDLE;
				end else begin
					next_rf_state = RF_HALT_1;
				end
			end
			RF_IDLE: begin
				if (!invalid_active) begin
					next_rf_state = RF_PASS;
				end
			end
			default: begin
				next_rf_state = RF_PASS;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rf_state <= RF_PASS;
		end else begin
			rf_state <= next_rf_state;
		end
	end

	// count of halt pairs sent since the invalid bus was selected
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			halt_pairs <= '0;
		end else if (next_rf_state == RF_PASS) begin
			halt_pairs <= '0;
		end else if (next_rf_state == RF_HALT_1 && halt_pairs != PAIR_LIMIT) begin
			halt_pairs <= halt_pairs + CNT_W'(1);
		end
	end

	// transmitter input; registered so a select change cannot glitch it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_input <= CSW_BUS_ZERO;
		end else begin
			case (next_rf_state)
				RF_HALT_1, RF_HALT_2: tx_input <= make_symbol(CSW_SYM_HALT);
				RF_IDLE:              tx_input <= make_symbol(CSW_SYM_IDLE);
				default:              tx_input <= switch_tx;
			endcase
		end
	end

	// ****************************************************************
	// indicate ports
	// ****************************************************************

	// first port carries the receiver bus
	csw_indicate_port #(
		.PRESENT (1'b1)
	) u_first_port (
		.clock       (clock),
		.rst         (rst),
		.port_enable (first_indicate_port_enable),
		.source      (receiver_bus),
		.port_out    (first_indicate_bus),
		.port_oe     (first_indicate_oe)
	);

	// second port exists only on the dual-path variant
	csw_indicate_port #(
		.PRESENT (HAS_SECOND_PORT)
	) u_second_port (
		.clock       (clock),
		.rst         (rst),
		.port_enable (second_indicate_port_enable),
		.source      (switch_second),
		.port_out    (second_indicate_bus),
		.port_oe     (second_indicate_oe)
	);

	// ****************************************************************
	// register read path
	// ****************************************************************

	// status: filter state in the high nibble, halt pairs sent below
	always_comb begin
		status_word      = 8'h00;
		status_word[7:4] = rf_state;
		status_word[3:0] = 4'(halt_pairs);
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				CSW_ADDR_CONFIG:   reg_rdata <= config_reg;
				CSW_ADDR_TX_STATE: reg_rdata <= {5'h00, transmit_mode_field};
				CSW_ADDR_STATUS:   reg_rdata <= status_word;
				default:           reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// [hdl/csw_indicate_port.sv]
// one indicate output port toward a media access controller
`timescale 1ns/10ps

module csw_indicate_port
	import csw_pkg::*;
#(
	parameter bit PRESENT = 1'b1
) (
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire logic     port_enable,
	input  wire csw_bus_t source,
	output csw_bus_t      port_out,
	output logic          port_oe
);

	// ****************************************************************
	// output stage
	// ****************************************************************

	// data is registered so the pins change only on the clock edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port_out <= CSW_BUS_ZERO;
		end else if (PRESENT) begin
			port_out <= source;
		end else begin
			port_out <= CSW_BUS_ZERO;
		end
	end

	// a missing port keeps its pins released whatever software writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port_oe <= 1'b0;
		end else begin
			port_oe <= PRESENT && port_enable;
		end
	end

endmodule

// [hdl/csw_pkg.sv]
// shared constants and types of the configuration switch port selector
package csw_pkg;

	// ****************************************************************
	// register map (byte offsets on the management port)
	// ****************************************************************
	localparam logic [7:0] CSW_ADDR_CONFIG   = 8'h00; // switch configuration register
	localparam logic [7:0] CSW_ADDR_TX_STATE = 8'h01; // current_transmit_state_reg
	localparam logic [7:0] CSW_ADDR_STATUS   = 8'h02; // read-only filter status

	// ****************************************************************
	// configuration register fields
	// ****************************************************************
	localparam int CSW_BIT_SECOND_SEL_LO  = 2; // second_indicate_select_lo
	localparam int CSW_BIT_SECOND_SEL_HI  = 3; // second_indicate_select_hi
	localparam int CSW_BIT_TX_SEL_LO      = 4; // tx_source_select_lo
	localparam int CSW_BIT_TX_SEL_HI      = 5; // tx_source_select_hi
	localparam int CSW_BIT_FIRST_ENABLE   = 6; // first_indicate_port_enable
	localparam int CSW_BIT_SECOND_ENABLE  = 7; // second_indicate_port_enable
	localparam logic [7:0] CSW_CONFIG_RESET   = 8'h00;
	localparam logic [7:0] CSW_CONFIG_WR_MASK = 8'hFC; // d0 and d1 read as zero

	// ****************************************************************
	// transmit state register fields
	// ****************************************************************
	localparam int CSW_TM_LSB = 0;
	localparam int CSW_TM_MSB = 2;
	localparam logic [2:0] CSW_TM_ACTIVE    = 3'h0; // active transmit
	localparam logic [2:0] CSW_TM_RESET     = 3'h0;

	// ****************************************************************
	// symbol codes on the switch buses (control flag set)
	// ****************************************************************
	localparam logic [7:0] CSW_SYM_INVALID = 8'h00;
	localparam logic [7:0] CSW_SYM_HALT    = 8'h44;
	localparam logic [7:0] CSW_SYM_IDLE    = 8'hFF;

	// switch bus encoding, shared by transmit and second indicate selectors
	typedef enum logic [1:0] {
		CSW_BUS_INVALID  = 2'h0,
		CSW_BUS_RECEIVER = 2'h1,
		CSW_BUS_REQ_A    = 2'h2,
		CSW_BUS_REQ_B    = 2'h3
	} csw_bus_sel_t;

	// one symbol on a switch bus or an indicate port
	typedef struct packed {
		logic       parity;
		logic       control;
		logic [7:0] data;
	} csw_bus_t;

	localparam csw_bus_t CSW_BUS_ZERO = '{parity: 1'b0, control: 1'b0, data: 8'h00};

endpackage

// [sim/config_switch_port_select_tb_top.sv]
// testbench of the configuration switch port selector
`timescale 1ns/10ps

module config_switch_port_select_tb_top;
	import csw_pkg::*;
	logic       clock, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rdata2;
	logic       foe, soe, soe2;
	csw_bus_t   rcv = '{parity: 1'b1, control: 1'b0, data: 8'h3C};
	csw_bus_t   req_a, req_b, tx, fbus, sbus, sbus2, mac_rx;
	csw_bus_t   busv [4];
	int         fail_count = 0, cmp_count = 0;
	// rows: config, tx source, second source, first oe, second oe
	logic [13:0] rows [4] = '{{8'h54, 2'h1, 2'h1, 2'b10}, {8'hA8, 2'h2, 2'h2, 2'b01},
		{8'hFC, 2'h3, 2'h3, 2'b11}, {8'h38, 2'h3, 2'h2, 2'b00}};

	csw_config_switch #(.HALT_PAIR_MAX(2)) u_csw_config_switch (.clock(clock), .rst(rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .receiver_bus(rcv), .request_a_bus(req_a),
		.request_b_bus(req_b), .tx_input(tx), .first_indicate_bus(fbus), .first_indicate_oe(foe),
		.second_indicate_bus(sbus), .second_indicate_oe(soe));
	// single-path variant shares every input
	csw_config_switch #(.HAS_SECOND_PORT(1'b0), .HALT_PAIR_MAX(2)) u2 (.clock(clock), .rst(rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata2), .receiver_bus(rcv), .request_a_bus(req_a),
		.request_b_bus(req_b), .tx_input(), .first_indicate_bus(), .first_indicate_oe(),
		.second_indicate_bus(sbus2), .second_indicate_oe(soe2));
	csw_mac_model u_csw_mac_model (.clock(clock), .indicate_bus(fbus), .indicate_oe(foe), .request_a_bus(req_a),
		.request_b_bus(req_b), .last_rx(mac_rx));

	// ****************************************************************
	// bus tasks and compare
	// ****************************************************************
	task automatic chk(input logic [9:0] g, input logic [9:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the read edge
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(rdata, e, "readback");
		chk(rdata2, e, "readback variant");
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		#100000;
		fail_count++;
		finish_test;
	end

	initial begin
		#1;
		busv = '{'0, rcv, req_a, req_b};
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rd_reg(CSW_ADDR_CONFIG, 8'h00);
		rd_reg(CSW_ADDR_TX_STATE, 8'h00);
		wr_reg(8'h7F, 8'hFF);
		rd_reg(8'h7F, 8'h00);
		rd_reg(CSW_ADDR_CONFIG, 8'h00);
		foreach (rows[i]) begin
			wr_reg(CSW_ADDR_CONFIG, rows[i][13:6]);
			repeat (2) @(posedge clock);
			#1;
			chk(tx, busv[rows[i][5:4]], "tx route");
			chk(sbus, busv[rows[i][3:2]], "second route");
			chk(foe, rows[i][1], "first enable");
			chk(soe, rows[i][0], "second enable");
			chk(fbus, rcv, "first data");
			if (rows[i][1])
				chk(mac_rx, rcv, "far side data");
		end
		wr_reg(CSW_ADDR_CONFIG, 8'hFF);
		repeat (2) @(posedge clock);
		#1;
		chk(soe2, 1'b0, "variant enable");
		chk(sbus2, CSW_BUS_ZERO, "variant pins");
		rd_reg(CSW_ADDR_CONFIG, 8'hFC);
		// two halt pairs, then idle for good
		wr_reg(CSW_ADDR_CONFIG, 8'h00);
		for (int i = 0; i < 7; i++) begin
			@(posedge clock);
			#1;
			chk(tx, {2'b01, i < 4 ? CSW_SYM_HALT : CSW_SYM_IDLE}, "filter");
		end
		rd_reg(CSW_ADDR_STATUS, 8'h82);
		wr_reg(CSW_ADDR_TX_STATE, 8'h01);
		repeat (2) @(posedge clock);
		#1;
		chk(tx, {2'b01, CSW_SYM_INVALID}, "invalid bus");
		rd_reg(CSW_ADDR_TX_STATE, 8'h01);
		// mid-run reset: pins release at once, registers and filter restart
		wr_reg(CSW_ADDR_CONFIG, 8'hC4);
		repeat (2) @(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		#1;
		chk(foe, 1'b0, "reset first enable");
		chk(soe, 1'b0, "reset second enable");
		chk(tx, CSW_BUS_ZERO, "reset tx");
		@(posedge clock);
		rst <= 1'b0;
		rd_reg(CSW_ADDR_CONFIG, 8'h00);
		chk(tx, {2'b01, CSW_SYM_HALT}, "filter after reset");
		rd_reg(CSW_ADDR_TX_STATE, 8'h00);
		finish_test;
	end
endmodule

// [sim/csw_config_switch_properties.sv]
// checker for the configuration switch port selector
`timescale 1ns/10ps

module csw_config_switch_chk
	import csw_pkg::*;
#(
	parameter bit          HAS_SECOND_PORT = 1'b1,
	parameter int unsigned HALT_PAIR_MAX   = 8
) (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire csw_bus_t   receiver_bus,
	input wire csw_bus_t   request_a_bus,
	input wire csw_bus_t   request_b_bus,
	input wire csw_bus_t   tx_input,
	input wire csw_bus_t   first_indicate_bus,
	input wire logic       first_indicate_oe,
	input wire csw_bus_t   second_indicate_bus,
	input wire logic       second_indicate_oe
);
	// ****************************************************************
	// shadow of software state
	// ****************************************************************
	logic       up;
	logic       up_half;
	logic [7:0] cfg_q;
	logic [2:0] mode_q;
	logic [7:0] fc;
	wire        fill = cfg_q[5:4] == 2'h0 && mode_q == CSW_TM_ACTIVE;

	function automatic csw_bus_t pick(input logic [1:0] s);
		return s == 2'h1 ? receiver_bus : s == 2'h2 ? request_a_bus : request_b_bus;
	endfunction

	// disable iff reads current values, so a one-stage flag would already be up at
	// the first edge after release while outputs still show reset values; wait two edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			up_half <= 1'b0;
			up     <= 1'b0;
			cfg_q  <= CSW_CONFIG_RESET;
			mode_q <= CSW_TM_RESET;
			fc     <= 8'h00;
		end else begin
			up_half <= 1'b1;
			up      <= up_half;
			if (reg_wr && reg_addr == CSW_ADDR_CONFIG)
				cfg_q <= reg_wdata & CSW_CONFIG_WR_MASK;
			if (reg_wr && reg_addr == CSW_ADDR_TX_STATE)
				mode_q <= reg_wdata[2:0];
			fc <= !fill ? 8'h00 : (fc == 8'hFF ? fc : fc + 8'h01); // saturates
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst || !up);

	a_first_oe_track: assert property (first_indicate_oe == $past(cfg_q[6]))
		else $error("first port enable wrong");
	a_second_oe_track: assert property (second_indicate_oe == (HAS_SECOND_PORT && $past(cfg_q[7])))
		else $error("second port enable wrong");
	a_first_bus_copy: assert property (first_indicate_bus == $past(receiver_bus))
		else $error("first port data wrong");
	a_tx_route: assert property (cfg_q[5:4] != 2'h0 |=> tx_input == $past(pick(cfg_q[5:4])))
		else $error("transmit route wrong");
	a_second_route: assert property (cfg_q[3:2] != 2'h0 |=>
		second_indicate_bus == (HAS_SECOND_PORT ? $past(pick(cfg_q[3:2])) : CSW_BUS_ZERO))
		else $error("second route wrong");
	a_halt_burst: assert property (fc != 0 && fc <= 2 * HALT_PAIR_MAX |-> tx_input.data == CSW_SYM_HALT)
		else $error("halt expected");
	a_idle_after_halts: assert property (fc > 2 * HALT_PAIR_MAX |-> tx_input.data == CSW_SYM_IDLE)
		else $error("idle expected");
	a_invalid_pass: assert property (cfg_q[5:4] == 2'h0 && mode_q != CSW_TM_ACTIVE |=>
		tx_input.data == CSW_SYM_INVALID)
		else $error("invalid symbol expected");
	a_read_config: assert property (reg_rd && reg_addr == CSW_ADDR_CONFIG |=> reg_rdata == $past(cfg_q))
		else $error("config readback wrong");

	c_idle: cover property (fc == 2 * HALT_PAIR_MAX + 1);
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
	c_second_on: cover property ($rose(second_indicate_oe));
endmodule

bind csw_config_switch csw_config_switch_chk #(.HAS_SECOND_PORT(HAS_SECOND_PORT), .HALT_PAIR_MAX(HALT_PAIR_MAX))
	u_chk (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .receiver_bus, .request_a_bus,
	.request_b_bus, .tx_input, .first_indicate_bus, .first_indicate_oe, .second_indicate_bus, .second_indicate_oe);

// [sim/csw_mac_model.sv]
// far-side controller model: drives both request buses, samples an indicate port
`timescale 1ns/10ps

module csw_mac_model
	import csw_pkg::*;
(
	input  wire logic     clock,
	input  wire csw_bus_t indicate_bus,
	input  wire logic     indicate_oe,
	output csw_bus_t      request_a_bus,
	output csw_bus_t      request_b_bus,
	output csw_bus_t      last_rx
);
	// fixed symbols with odd parity keep the route checks simple
	assign request_a_bus = '{parity: 1'b1, control: 1'b0, data: 8'hA5};
	assign request_b_bus = '{parity: 1'b0, control: 1'b1, data: 8'h5A};

	// a released port floats, so it is never sampled
	always_ff @(posedge clock) begin
		if (indicate_oe)
			last_rx <= indicate_bus;
	end
endmodule
